// ==== hdl/iac_top.sv ====
/*
 Output control of a two-channel interleaved 12-bit converter.
 Assumes raw samples arrive per channel on the half-rate phase; capture
 hold and config words come from outside the clock domain.
*/
// Notes on behaviour
// - Two 12-bit channels sample alternately; aggregate rate doubles.
// - Encode clock halved and sent to channels in antiphase.
// - Gain, offset and timing mismatch corrected before output.
// - Two separate 12-bit buses, each at half conversion rate.
// - Default output format is twos complement.
// - Each bus has its own data-ready strobe.
// - Configuration copied from nonvolatile store at power-up.
// - Active-low reset reloads the configuration.
// - Strobes and data held high during reset and reload.
// - Loading starts on reset release.
// - Reload finishes within 600 ms of release.
// - Resumed strobe toggling marks end of reset.
// - Capture hold accepted synchronously or asynchronously.
// - Capture hold low suppresses both strobes.
// - Strobes restart together at next channel A strobe.
// - Each strobe is a true and complement pair.
// - Bit 0 is LSB; each bit a true and complement pair.
`timescale 1ns/1ns
module iac_top #(
   parameter int RELOAD_CYCLES = iac_pkg::RELOAD_CYCLES
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Raw conversion results, offset binary
   input wire logic [iac_pkg::SAMPLE_W-1:0] raw_a_i,
   input wire logic [iac_pkg::SAMPLE_W-1:0] raw_b_i,
   // Nonvolatile configuration read port
   output logic [1:0] nvm_addr_o,
   input wire logic [iac_pkg::COEF_W-1:0] nvm_data_i,
   // Capture hold, active low
   input wire logic capture_hold_input_b_i,
   // Encode phases to the channels
   output logic enc_a_o,
   output logic enc_b_o,
   // Channel A output pair
   output logic [iac_pkg::SAMPLE_W-1:0] chan_a_sample_p_o,
   output logic [iac_pkg::SAMPLE_W-1:0] chan_a_sample_n_o,
   output logic chan_a_ready_strobe_p_o,
   output logic chan_a_ready_strobe_n_o,
   // Channel B output pair
   output logic [iac_pkg::SAMPLE_W-1:0] chan_b_sample_p_o,
   output logic [iac_pkg::SAMPLE_W-1:0] chan_b_sample_n_o,
   output logic chan_b_ready_strobe_p_o,
   output logic chan_b_ready_strobe_n_o
);
   iac_corr_if corr ();
   iac_pkg::iac_state_t state_reg;
   logic [31:0] load_cnt_reg;
   logic [1:0] coef_idx_reg;
   logic phase_reg;
   logic hold_s1_reg;
   logic hold_s2_reg;
   logic gate_reg;
   logic run;
   logic [iac_pkg::SAMPLE_W-1:0] cor_a;
   logic [iac_pkg::SAMPLE_W-1:0] cor_b;
   logic [iac_pkg::SAMPLE_W-1:0] nvm_s1_reg;
   logic [iac_pkg::SAMPLE_W-1:0] nvm_s2_reg;
   logic [iac_pkg::COEF_W-1:0] gain_reg;
   logic [iac_pkg::COEF_W-1:0] skew_reg;
   logic [iac_pkg::COEF_W-1:0] offa_reg;
   logic [iac_pkg::COEF_W-1:0] offb_reg;

   assign run = (state_reg == iac_pkg::IAC_ST_RUN);
   assign corr.gain_b = gain_reg;
   assign corr.skew_b = skew_reg;
   assign corr.offs_a = offa_reg;
   assign corr.offs_b = offb_reg;

   // Load sequencer: starts at reset release, bounded by reload time
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_reg <= iac_pkg::IAC_ST_IDLE;
         load_cnt_reg <= '0;
         coef_idx_reg <= '0;
      end else begin
         unique case (state_reg)
            iac_pkg::IAC_ST_IDLE: begin
               state_reg <= iac_pkg::IAC_ST_LOAD;
            end
            iac_pkg::IAC_ST_LOAD: begin
               load_cnt_reg <= load_cnt_reg + 32'h1;
               coef_idx_reg <= coef_idx_reg + 2'h1;
               if (load_cnt_reg >= 32'(RELOAD_CYCLES - 1)) begin
                  state_reg <= iac_pkg::IAC_ST_RUN;
               end
            end
            iac_pkg::IAC_ST_RUN: begin
               state_reg <= iac_pkg::IAC_ST_RUN;
            end
            default: state_reg <= iac_pkg::IAC_ST_IDLE;
         endcase
      end
   end

   // NVM address steps through coefficients while loading
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         nvm_addr_o <= '0;
      end else begin
         nvm_addr_o <= coef_idx_reg;
      end
   end

   // NVM data synchronised, then captured by index (three cycles of lag)
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         nvm_s1_reg <= '0;
         nvm_s2_reg <= '0;
         gain_reg <= iac_pkg::GAIN_UNITY;
         skew_reg <= '0;
         offa_reg <= '0;
         offb_reg <= '0;
      end else begin
         nvm_s1_reg <= nvm_data_i;
         nvm_s2_reg <= nvm_s1_reg;
         if (state_reg == iac_pkg::IAC_ST_LOAD && load_cnt_reg >= 32'h3) begin
            unique case (coef_idx_reg - 2'h3)
               2'h0: gain_reg <= nvm_s2_reg;
               2'h1: skew_reg <= nvm_s2_reg;
               2'h2: offa_reg <= nvm_s2_reg;
               2'h3: offb_reg <= nvm_s2_reg;
            endcase
         end
      end
   end

   // Half-rate antiphase encode for the two channels
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         phase_reg <= 1'b0;
         enc_a_o <= 1'b0;
         enc_b_o <= 1'b1;
      end else begin
         phase_reg <= ~phase_reg;
         enc_a_o <= ~phase_reg;
         enc_b_o <= phase_reg;
      end
   end

   // Capture hold synchronizer
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         hold_s1_reg <= 1'b1;
         hold_s2_reg <= 1'b1;
      end else begin
         hold_s1_reg <= capture_hold_input_b_i;
         hold_s2_reg <= hold_s1_reg;
      end
   end

   // Strobe gate: drops at once, reopens on a channel A phase once running
   // Opening only in run keeps the held-high words from being strobed out
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         gate_reg <= 1'b0;
      end else if (!hold_s2_reg) begin
         gate_reg <= 1'b0;
      end else if (!phase_reg && run) begin
         gate_reg <= 1'b1;
      end
   end

   iac_corrector u_corr (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .corr(corr),
      .raw_a_i(raw_a_i),
      .raw_b_i(raw_b_i),
      .en_i(phase_reg),
      .cor_a_o(cor_a),
      .cor_b_o(cor_b)
   );

   // Output buses and strobes, held high until running
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         chan_a_sample_p_o <= iac_pkg::ALL_ONES;
         chan_a_sample_n_o <= iac_pkg::ALL_ONES;
         chan_b_sample_p_o <= iac_pkg::ALL_ONES;
         chan_b_sample_n_o <= iac_pkg::ALL_ONES;
         chan_a_ready_strobe_p_o <= 1'b1;
         chan_a_ready_strobe_n_o <= 1'b1;
         chan_b_ready_strobe_p_o <= 1'b1;
         chan_b_ready_strobe_n_o <= 1'b1;
      end else if (!run) begin
         chan_a_sample_p_o <= iac_pkg::ALL_ONES;
         chan_a_sample_n_o <= iac_pkg::ALL_ONES;
         chan_b_sample_p_o <= iac_pkg::ALL_ONES;
         chan_b_sample_n_o <= iac_pkg::ALL_ONES;
         chan_a_ready_strobe_p_o <= 1'b1;
         chan_a_ready_strobe_n_o <= 1'b1;
         chan_b_ready_strobe_p_o <= 1'b1;
         chan_b_ready_strobe_n_o <= 1'b1;
      end else begin
         // Data moves on strobe fall, or freely while strobes are shut off
         if (!phase_reg || !gate_reg) begin
            chan_a_sample_p_o <= cor_a;
            chan_a_sample_n_o <= ~cor_a;
            chan_b_sample_p_o <= cor_b;
            chan_b_sample_n_o <= ~cor_b;
         end
         chan_a_ready_strobe_p_o <= gate_reg & hold_s2_reg & phase_reg;
         chan_a_ready_strobe_n_o <= ~(gate_reg & hold_s2_reg & phase_reg);
         chan_b_ready_strobe_p_o <= gate_reg & hold_s2_reg & phase_reg;
         chan_b_ready_strobe_n_o <= ~(gate_reg & hold_s2_reg & phase_reg);
      end
   end

   // Assertions
   property p_hold_high;
      @(posedge clk_i) disable iff (!rst_b_i)
         (!run && !$rose(run)) |=> (chan_a_sample_p_o == iac_pkg::ALL_ONES) && chan_b_ready_strobe_p_o;
   endproperty
   a_hold_high: assert property (p_hold_high) else $error("outputs not high before run");

   property p_pairs;
      @(posedge clk_i) disable iff (!rst_b_i)
         run |=> (chan_a_ready_strobe_n_o == ~chan_a_ready_strobe_p_o) &&
            (chan_b_sample_n_o == ~chan_b_sample_p_o);
   endproperty
   a_pairs: assert property (p_pairs) else $error("complement pair mismatch");

   property p_suppress;
      @(posedge clk_i) disable iff (!rst_b_i)
         (run && !hold_s2_reg) |=> !chan_a_ready_strobe_p_o && !chan_b_ready_strobe_p_o;
   endproperty
   a_suppress: assert property (p_suppress) else $error("strobe not suppressed");

   property p_together;
      @(posedge clk_i) disable iff (!rst_b_i)
         1'b1 |-> chan_a_ready_strobe_p_o == chan_b_ready_strobe_p_o;
   endproperty
   a_together: assert property (p_together) else $error("strobes misaligned");

   property p_sync;
      @(posedge clk_i) disable iff (!rst_b_i)
         $fell(capture_hold_input_b_i) ##1 !capture_hold_input_b_i |=> !hold_s2_reg;
   endproperty
   a_sync: assert property (p_sync) else $error("hold not synchronised in two cycles");

   property p_antiphase;
      @(posedge clk_i) disable iff (!rst_b_i)
         rst_b_i ##1 rst_b_i |-> (enc_a_o != enc_b_o) && (enc_a_o != $past(enc_a_o));
   endproperty
   a_antiphase: assert property (p_antiphase) else $error("encode phases wrong");

   property p_start;
      @(posedge clk_i) disable iff (!rst_b_i)
         rst_b_i && (state_reg == iac_pkg::IAC_ST_IDLE) |=> (state_reg == iac_pkg::IAC_ST_LOAD);
   endproperty
   a_start: assert property (p_start) else $error("load did not start");

   property p_data_stable;
      @(posedge clk_i) disable iff (!rst_b_i)
         (run && $past(run) && chan_a_ready_strobe_p_o) |-> $stable(chan_a_sample_p_o);
   endproperty
   a_data_stable: assert property (p_data_stable) else $error("data moved on strobe high");

   property p_toggle;
      @(posedge clk_i) disable iff (!rst_b_i)
         (run && chan_a_ready_strobe_p_o && hold_s2_reg) |=> !chan_a_ready_strobe_p_o;
   endproperty
   a_toggle: assert property (p_toggle) else $error("strobe not toggling");
endmodule : iac_top

// ==== hdl/iac_pkg.sv ====
/*
 Constants shared by the interleaved converter output control block.
 Assumes a single 20 MHz system clock.
*/
package iac_pkg;
   localparam int SAMPLE_W = 12;
   localparam int CLK_PERIOD_NS = 50;
   localparam int CLK_HZ = 20000000;
   // Configuration reload bound, in ms as printed
   localparam int RELOAD_MAX_MS = 600;
   localparam int RELOAD_CYCLES = (CLK_HZ / 1000) * RELOAD_MAX_MS;
   // Least reset pulse, in ns
   localparam int RESET_MIN_NS = 200;
   localparam int RESET_MIN_CYCLES = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Least async hold pulse, in ns
   localparam int HOLD_MIN_NS = 5;
   localparam int HOLD_MIN_CYCLES = ((HOLD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ?
      1 : ((HOLD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   // Number of correction coefficients and their width
   localparam int COEF_N = 4;
   localparam int COEF_W = 12;
   localparam logic [SAMPLE_W-1:0] ALL_ONES = 12'hFFF;
   localparam logic [SAMPLE_W-1:0] OFFSET_BIN = 12'h800;
   localparam logic [COEF_W-1:0] GAIN_UNITY = 12'h400;
   typedef enum logic [1:0] {
      IAC_ST_IDLE = 2'b00,
      IAC_ST_LOAD = 2'b01,
      IAC_ST_RUN = 2'b11
   } iac_state_t;
endpackage : iac_pkg

// ==== hdl/iac_corr_if.sv ====
/*
 Interface carrying correction coefficients from loader to corrector.
 Assumes both ends share clk_i.
*/
`timescale 1ns/1ns
interface iac_corr_if;
   logic [iac_pkg::COEF_W-1:0] gain_b;
   logic [iac_pkg::COEF_W-1:0] skew_b;
   logic signed [iac_pkg::COEF_W-1:0] offs_a;
   logic signed [iac_pkg::COEF_W-1:0] offs_b;
   modport src (output gain_b, skew_b, offs_a, offs_b);
   modport dst (input gain_b, skew_b, offs_a, offs_b);
endinterface : iac_corr_if

// ==== hdl/iac_corrector.sv ====
/*
 Channel mismatch corrector: gain, offset and timing skew for channel B.
 Assumes coefficients stable while running; one-cycle latency.
*/
`timescale 1ns/1ns
module iac_corrector (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Coefficients
   iac_corr_if.dst corr,
   // Raw samples, offset binary
   input wire logic [iac_pkg::SAMPLE_W-1:0] raw_a_i,
   input wire logic [iac_pkg::SAMPLE_W-1:0] raw_b_i,
   input wire logic en_i,
   // Corrected twos-complement samples
   output logic [iac_pkg::SAMPLE_W-1:0] cor_a_o,
   output logic [iac_pkg::SAMPLE_W-1:0] cor_b_o
);
   logic signed [iac_pkg::SAMPLE_W-1:0] a_tc;
   logic signed [iac_pkg::SAMPLE_W-1:0] b_tc;
   logic signed [iac_pkg::SAMPLE_W-1:0] b_prev_reg;
   logic signed [25:0] b_gain;
   logic signed [25:0] b_skew;
   logic signed [13:0] a_sum;
   logic signed [13:0] b_sum;

   // Offset binary to twos complement by MSB flip
   assign a_tc = raw_a_i ^ iac_pkg::OFFSET_BIN;
   assign b_tc = raw_b_i ^ iac_pkg::OFFSET_BIN;
   // Gain and fractional-delay interpolation, Q10
   assign b_gain = (b_tc * $signed({2'b00, corr.gain_b})) >>> 10;
   assign b_skew = ((b_prev_reg - b_tc) * $signed({2'b00, corr.skew_b})) >>> 10;
   assign a_sum = 14'(a_tc) + 14'(corr.offs_a);
   assign b_sum = 14'(b_gain) + 14'(b_skew) + 14'(corr.offs_b);

   // Sample history and saturated outputs
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         b_prev_reg <= '0;
         cor_a_o <= '0;
         cor_b_o <= '0;
      end else if (en_i) begin
         b_prev_reg <= b_tc;
         cor_a_o <= (a_sum > 14'sd2047) ? 12'h7FF : (a_sum < -14'sd2048) ? 12'h800 : a_sum[11:0];
         cor_b_o <= (b_sum > 14'sd2047) ? 12'h7FF : (b_sum < -14'sd2048) ? 12'h800 : b_sum[11:0];
      end
   end
endmodule : iac_corrector

// ==== tb/iac_capture_model.sv ====
/*
 Far-side model: configuration store and capture logic for both buses.
 Assumes the same clk_i as the device; strobe and data are the true pins.
*/
`timescale 1ns/1ns
module iac_capture_model #(
   // Channel offsets held in the store
   parameter logic [11:0] OFFS_A = 12'h010,
   parameter logic [11:0] OFFS_B = 12'hFF0
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Configuration store port
   input wire logic [1:0] nvm_addr_i,
   output logic [iac_pkg::COEF_W-1:0] nvm_data_o,
   // Device output buses
   input wire logic strobe_a_i,
   input wire logic strobe_b_i,
   input wire logic [iac_pkg::SAMPLE_W-1:0] data_a_i,
   input wire logic [iac_pkg::SAMPLE_W-1:0] data_b_i,
   // Captured words and reset-done flag
   output logic [iac_pkg::SAMPLE_W-1:0] cap_a_o,
   output logic [iac_pkg::SAMPLE_W-1:0] cap_b_o,
   output logic ready_o
);
   logic prev_a_reg;
   logic prev_b_reg;

   // Store: unity gain, no skew, offsets that only a reload can bring in
   always_comb begin
      case (nvm_addr_i)
         2'h0: nvm_data_o = iac_pkg::GAIN_UNITY;
         2'h2: nvm_data_o = OFFS_A;
         2'h3: nvm_data_o = OFFS_B;
         default: nvm_data_o = 12'h000;
      endcase
   end

   // Latch each bus on the first high cycle of its own strobe
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         prev_a_reg <= 1'b1;
         prev_b_reg <= 1'b1;
         cap_a_o <= 12'h000;
         cap_b_o <= 12'h000;
         ready_o <= 1'b0;
      end else begin
         prev_a_reg <= strobe_a_i;
         prev_b_reg <= strobe_b_i;
         if (strobe_a_i && !prev_a_reg) begin
            cap_a_o <= data_a_i;
            ready_o <= 1'b1; // Held-high pins alone never count as done
         end
         if (strobe_b_i && !prev_b_reg) begin
            cap_b_o <= data_b_i;
         end
      end
   end
endmodule : iac_capture_model

// ==== tb/iac_top_test.sv ====
/*
 Self-checking bench for the interleaved converter output control.
 Assumes a short reload count so the run stays a few hundred cycles.
*/
`timescale 1ns/1ns
module iac_top_test;
   localparam int RELOAD = 20;
   localparam logic [11:0] OFF_A = 12'h010;
   localparam logic [11:0] OFF_B = 12'hFF0;
   logic clk_i;
   logic rst_b_i;
   logic hold_b;
   logic [11:0] raw_a, raw_b, nvm_data, a_p, a_n, b_p, b_n, cap_a, cap_b;
   logic [1:0] nvm_addr;
   logic enc_a, enc_b, sa_p, sa_n, sb_p, sb_n, ready;
   int err_total;
   int checked;
   logic [31:0] seed = 32'h85e3;
   logic [11:0] corners [4] = '{12'h000, 12'h800, 12'hFFF, 12'h7FF};

   iac_top #(.RELOAD_CYCLES(RELOAD)) u_iac_top (.clk_i(clk_i), .rst_b_i(rst_b_i),
      .raw_a_i(raw_a), .raw_b_i(raw_b), .nvm_addr_o(nvm_addr), .nvm_data_i(nvm_data),
      .capture_hold_input_b_i(hold_b), .enc_a_o(enc_a), .enc_b_o(enc_b),
      .chan_a_sample_p_o(a_p), .chan_a_sample_n_o(a_n),
      .chan_a_ready_strobe_p_o(sa_p), .chan_a_ready_strobe_n_o(sa_n),
      .chan_b_sample_p_o(b_p), .chan_b_sample_n_o(b_n),
      .chan_b_ready_strobe_p_o(sb_p), .chan_b_ready_strobe_n_o(sb_n));

   iac_capture_model #(.OFFS_A(OFF_A), .OFFS_B(OFF_B)) u_iac_capture_model (.clk_i(clk_i),
      .rst_b_i(rst_b_i), .nvm_addr_i(nvm_addr), .nvm_data_o(nvm_data), .strobe_a_i(sa_p),
      .strobe_b_i(sb_p), .data_a_i(a_p), .data_b_i(b_p), .cap_a_o(cap_a),
      .cap_b_o(cap_b), .ready_o(ready));

   // Clock at 20 MHz
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   // Offset binary to twos complement, plus channel offset, saturated
   function automatic logic [11:0] expect_word(input logic [11:0] r, input logic [11:0] off);
      int v;
      v = int'($signed(r ^ 12'h800)) + int'($signed(off));
      if (v > 2047) begin
         v = 2047;
      end else if (v < -2048) begin
         v = -2048;
      end
      return v[11:0];
   endfunction : expect_word

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic stop_test();
      $display("checked=%0d err_total=%0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : stop_test

   // Every data and strobe pin, true and complement, must read high
   task automatic idle_check(input int n);
      repeat (n) begin
         @(negedge clk_i);
         chk({a_p, a_n, b_p, b_n, sa_p, sa_n, sb_p, sb_n}, {52{1'b1}});
      end
   endtask : idle_check

   task automatic wait_strobe();
      int n;
      n = 0;
      // Held-high pins show both halves at 1; a real strobe has them apart
      while (!(sa_p === 1'b1 && sa_n === 1'b0) && n < RELOAD + 50) begin
         @(negedge clk_i);
         n++;
      end
      chk({sa_p, sa_n}, 2'b10);
   endtask : wait_strobe

   // Running-mode pin relations, cycle by cycle
   task automatic run_check(input int n);
      logic prev;
      for (int k = 0; k < n; k++) begin
         @(negedge clk_i);
         if (k > 0) chk(sa_p, {~prev});
         prev = sa_p;
         chk(sb_p, sa_p);
         chk({a_n, b_n, sa_n, sb_n}, {~{a_p, b_p, sa_p, sb_p}});
         chk(enc_a, {~enc_b});
      end
   endtask : run_check

   task automatic data_step(input int i);
      logic [31:0] r;
      r = rnd();
      @(posedge clk_i);
      raw_a <= (i < 4) ? corners[i] : r[11:0];
      raw_b <= (i < 4) ? corners[3 - i] : r[27:16];
      run_check(12);
      chk(cap_a, expect_word(raw_a, OFF_A));
      chk(cap_b, expect_word(raw_b, OFF_B));
   endtask : data_step

   // Watchdog
   initial begin
      repeat (5000) @(posedge clk_i);
      err_total++;
      stop_test();
   end

   // Main sequence
   initial begin
      rst_b_i = 1'b0;
      hold_b = 1'b1;
      raw_a = 12'h000;
      raw_b = 12'h000;
      // Reset spans 20 edges, the idle checks and release edge included
      repeat (17) @(posedge clk_i);
      idle_check(3);
      for (int pass = 0; pass < 2; pass++) begin
         @(posedge clk_i);
         rst_b_i <= 1'b1;
         idle_check(RELOAD);
         wait_strobe();
         run_check(8);
         chk(ready, 1'b1);
         for (int i = 0; i < 10; i++) data_step(i);
         // Hold low: both strobes stop once the synchroniser passes it
         @(posedge clk_i);
         hold_b <= 1'b0;
         repeat (3) @(posedge clk_i);
         repeat (5) begin
            @(negedge clk_i);
            chk({sa_p, sb_p}, 2'b00);
         end
         @(posedge clk_i);
         hold_b <= 1'b1;
         wait_strobe();
         run_check(8);
         // Mid-run reset reloads the configuration
         @(posedge clk_i);
         rst_b_i <= 1'b0;
         idle_check(20);
      end
      stop_test();
   end
endmodule : iac_top_test
